// *** rtl/pc4_counter.sv ***
// Functional notes
// - The block holds a 4-bit binary count shown on four parallel count outputs.
// - All four count flip-flops update together on the rising clock edge.
// - A low preset strobe at a rising edge, with clear inactive, loads the preset inputs.
// - A low clear at once forces the count and the carry low, over load and enables.
// - The count goes up by one at an edge when clear, preset strobe and both enables are high.
// - The carry is high exactly while the trickle enable is high and the count is all ones.
// - With clear and preset strobe high and either enable low, the count holds its value.
// - Enable and preset strobe changes affect the count only at the next rising edge.
// - Counting from the maximum wraps to zero and counting carries on.
`timescale 1ns/1ns

module pc4_counter
    import pc4_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic async_clear_n,
    input wire logic preset_load_n,
    input wire logic count_enable_parallel,
    input wire logic count_enable_trickle,
    input wire logic [3:0] preset_in,
    output logic count_out_bit0,
    output logic count_out_bit1,
    output logic count_out_bit2,
    output logic count_out_bit3,
    output logic terminal_carry_out
);

    function automatic logic all_ones(input logic [3:0] value, input int unsigned top);
        logic result;
        result = 1'b1;
        for (int unsigned i = 0; i < 4; i++)
        begin
            if (i < top)
            begin
                result = result & value[i];
            end
        end
        return result;
    endfunction

    wire clear_n;
    wire load;
    wire count_en;
    wire [3:0] count;
    wire [3:0] toggle;
    wire [3:0] cell_q;
    pc4_mode_type mode;

    // Clear is a pin-level override, so it joins reset on the async input
    assign clear_n = arst_n & async_clear_n;
    assign load = ~preset_load_n;
    assign count_en = count_enable_parallel & count_enable_trickle;

    // Look-ahead: each bit toggles when every lower bit is one
    genvar gi;
    generate
        for (gi = 0; gi < PC4_WIDTH; gi++)
        begin : g_cell
            assign toggle[gi] = count_en & all_ones(count, gi);
            pc4_dt_cell u_cell (
                .clk_sys(clk_sys),
                .clear_n(clear_n),
                .load(load),
                .preset_bit(preset_in[gi]),
                .toggle(toggle[gi]),
                .q(cell_q[gi])
            );
        end
    endgenerate

    assign count = cell_q;
    assign count_out_bit0 = cell_q[0];
    assign count_out_bit1 = cell_q[1];
    assign count_out_bit2 = cell_q[2];
    assign count_out_bit3 = cell_q[3];

    // Carry stays combinational on the trickle enable so cascades need no extra stage
    assign terminal_carry_out = count_enable_trickle & all_ones(count, PC4_WIDTH);

    // Decoded operation, kept for observation by the checks below
    assign mode = !async_clear_n ? PC4_MODE_CLEAR :
        load ? PC4_MODE_LOAD :
        count_en ? PC4_MODE_COUNT : PC4_MODE_HOLD;

    // Value taken on entering an inhibit, kept however long the inhibit lasts
    logic hold_armed;
    logic [3:0] hold_value;
    wire hold_now;
    wire [3:0] next_hold_value;

    assign hold_now = mode == PC4_MODE_HOLD;
    assign next_hold_value = (hold_now && hold_armed) ? hold_value : count;

    always_ff @(posedge clk_sys or negedge clear_n)
    begin
        if (!clear_n)
        begin
            hold_armed <= PC4_BIT_RESET;
            hold_value <= PC4_COUNT_RESET;
        end
        else
        begin
            hold_armed <= hold_now;
            hold_value <= next_hold_value;
        end
    end

    sequence s_counting;
        (mode == PC4_MODE_COUNT) [*4];
    endsequence

    sequence s_loading;
        mode == PC4_MODE_LOAD;
    endsequence

    sequence s_at_terminal;
        mode == PC4_MODE_COUNT && count == PC4_TERMINAL;
    endsequence

    sequence s_load_inhibited;
        mode == PC4_MODE_LOAD && !count_en;
    endsequence

    sequence s_wrapped;
        s_at_terminal ##1 mode == PC4_MODE_COUNT;
    endsequence

    sequence s_pulse_end;
        s_at_terminal ##1 count_enable_trickle;
    endsequence

    sequence s_inhibit_top;
        mode == PC4_MODE_HOLD && count == PC4_TERMINAL;
    endsequence

    property p_load;
        @(posedge clk_sys) disable iff (!clear_n)
        s_loading |=> count == $past(preset_in);
    endproperty

    property p_burst;
        @(posedge clk_sys) disable iff (!clear_n)
        s_counting |=> count == 4'($past(count, 4) + 4'h4);
    endproperty

    preset_load_a: assert property (p_load)
        else $error("preset not loaded");

    preset_lsb_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        s_loading |=> count_out_bit0 == $past(preset_in[0])
            && count_out_bit3 == $past(preset_in[3]))
        else $error("preset bit order wrong");

    count_step_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        mode == PC4_MODE_COUNT |=> count == 4'($past(count) + PC4_STEP))
        else $error("count did not step by one");

    count_burst_a: assert property (p_burst)
        else $error("four counts did not add four");

    count_hold_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        mode == PC4_MODE_HOLD |=> $stable(count))
        else $error("count moved while inhibited");

    count_wrap_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        s_at_terminal |=> count == PC4_COUNT_RESET && !terminal_carry_out)
        else $error("count did not wrap to zero");

    carry_value_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        terminal_carry_out == (count_enable_trickle && count_out_bit0 && count_out_bit1
            && count_out_bit2 && count_out_bit3))
        else $error("carry does not match terminal count");

    carry_gate_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        !count_enable_trickle |-> !terminal_carry_out)
        else $error("carry high with trickle enable low");

    clear_force_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !async_clear_n |-> count == PC4_COUNT_RESET && !terminal_carry_out)
        else $error("clear did not force outputs low");

    sampled_only_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        $changed(count) |-> $past(mode) == PC4_MODE_LOAD || $past(mode) == PC4_MODE_COUNT)
        else $error("count changed without a load or count edge");

    load_inhibited_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        s_load_inhibited |=> count == $past(preset_in))
        else $error("preset ignored with enables low");

    preset_mid_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        s_loading |=> count_out_bit1 == $past(preset_in[1])
            && count_out_bit2 == $past(preset_in[2]))
        else $error("preset middle bits misplaced");

    top_toggle_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        mode == PC4_MODE_COUNT && &count[2:0] |=> count[3] != $past(count[3]))
        else $error("look-ahead did not reach the top bit");

    wrap_resume_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        s_wrapped |=> count == PC4_STEP)
        else $error("count did not resume after wrap");

    carry_pulse_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        s_pulse_end |-> !terminal_carry_out)
        else $error("carry outlived the terminal count");

    carry_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !async_clear_n && count_enable_trickle |-> !terminal_carry_out)
        else $error("carry high during clear");

    hold_long_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        hold_armed |-> count == hold_value)
        else $error("held count drifted");

    hold_carry_a: assert property (@(posedge clk_sys) disable iff (!clear_n)
        s_inhibit_top ##1 count_enable_trickle |-> terminal_carry_out)
        else $error("carry missing at the held top count");

endmodule

// *** rtl/pc4_dt_cell.sv ***
`timescale 1ns/1ns

module pc4_dt_cell
    import pc4_pkg::*;
(
    input wire logic clk_sys,
    input wire logic clear_n,
    input wire logic load,
    input wire logic preset_bit,
    input wire logic toggle,
    output logic q
);

    logic next_q;

    // Load beats toggle; otherwise toggle or keep
    assign next_q = load ? preset_bit : (q ^ toggle);

    always_ff @(posedge clk_sys or negedge clear_n)
    begin
        if (!clear_n)
        begin
            q <= PC4_BIT_RESET;
        end
        else
        begin
            q <= next_q;
        end
    end

endmodule

// *** rtl/pc4_pkg.sv ***
package pc4_pkg;

    localparam int PC4_WIDTH = 4;
    localparam logic [3:0] PC4_COUNT_RESET = 4'h0;
    localparam logic [3:0] PC4_TERMINAL = 4'hf;
    localparam logic [3:0] PC4_STEP = 4'h1;
    localparam logic PC4_BIT_RESET = 1'h0;

    typedef enum logic [3:0] {
        PC4_MODE_CLEAR = 4'h1,
        PC4_MODE_LOAD = 4'h2,
        PC4_MODE_COUNT = 4'h4,
        PC4_MODE_HOLD = 4'h8
    } pc4_mode_type;

endpackage

// *** verification/pc4_src.sv ***
`timescale 1ns/1ns

module pc4_src
    import pc4_pkg::*;
(
    input wire logic clk_sys,
    input wire pc4_mode_type mode,
    input wire logic [3:0] data,
    input wire logic trickle,
    input wire logic carry,
    output logic clear_n = 1'b0,
    output logic load_n = 1'b1,
    output logic en_par = 1'b0,
    output logic en_trk = 1'b0,
    output logic [3:0] preset = 4'h0,
    output logic [3:0] upper
);
    // Falling edge keeps every change clear of the sampling edge
    always @(negedge clk_sys)
    begin
        clear_n <= (mode != PC4_MODE_CLEAR);
        load_n <= (mode != PC4_MODE_LOAD);
        en_par <= (mode != PC4_MODE_HOLD);
        en_trk <= trickle;
        preset <= data;
    end
    // Next cascaded stage: carry is its trickle enable, parallel enable shared
    always @(posedge clk_sys or negedge clear_n)
    begin
        if (!clear_n)
        begin
            upper <= 4'h0;
        end
        else if (en_par && carry)
        begin
            upper <= upper + 4'h1;
        end
    end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ns

module tb_top
    import pc4_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    pc4_mode_type mode = PC4_MODE_CLEAR;
    logic [3:0] data = 4'h0;
    logic trickle = 1'b0;
    logic clear_n, load_n, en_par, en_trk, carry;
    logic [3:0] preset, last;
    wire [3:0] count, upper;
    int mismatches = 0;
    int checks = 0;

    always #25 clk_sys = ~clk_sys;

    pc4_src i_pc4_src(.clk_sys(clk_sys), .mode(mode), .data(data), .trickle(trickle),
        .clear_n(clear_n), .load_n(load_n), .en_par(en_par), .en_trk(en_trk),
        .preset(preset), .carry(carry), .upper(upper));
    pc4_counter i_pc4_counter(.clk_sys(clk_sys), .arst_n(arst_n), .async_clear_n(clear_n),
        .preset_load_n(load_n), .count_enable_parallel(en_par),
        .count_enable_trickle(en_trk), .preset_in(preset), .count_out_bit0(count[0]),
        .count_out_bit1(count[1]), .count_out_bit2(count[2]), .count_out_bit3(count[3]),
        .terminal_carry_out(carry));

    task automatic check(input logic [4:0] seen, input logic [4:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Count must not move before the edge that samples the new controls
    task automatic step(input pc4_mode_type m, input logic [3:0] d, input logic t,
        input logic [3:0] q);
        mode = m;
        data = d;
        trickle = t;
        @(negedge clk_sys);
        #1;
        check({carry, count}, {t && last == PC4_TERMINAL, last});
        @(posedge clk_sys);
        #1;
        check({carry, count}, {t && q == PC4_TERMINAL, q});
        last = q;
    endtask

    task automatic t_load;
        for (int v = 0; v < 16; v++)
            step(PC4_MODE_LOAD, v[3:0], v[0], v[3:0]);
        check({1'b0, upper}, 5'h00);
        $display("load test done");
    endtask

    task automatic t_count;
        step(PC4_MODE_LOAD, 4'hc, 1'b1, 4'hc);
        for (int v = 13; v < 19; v++)
            step(PC4_MODE_COUNT, 4'h5, 1'b1, v[3:0]);
        step(PC4_MODE_HOLD, 4'h5, 1'b1, 4'h2);
        step(PC4_MODE_LOAD, 4'hf, 1'b1, 4'hf);
        step(PC4_MODE_COUNT, 4'h5, 1'b0, 4'hf);
        step(PC4_MODE_HOLD, 4'h5, 1'b1, 4'hf);
        check({1'b0, upper}, 5'h02);
        $display("count test done");
    endtask

    task automatic t_clear;
        mode = PC4_MODE_CLEAR;
        @(negedge clk_sys);
        #1;
        check({carry, count}, 5'h00);
        @(posedge clk_sys);
        #1;
        check({carry, count}, 5'h00);
        last = 4'h0;
        $display("clear test done");
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        last = 4'h0;
        repeat (12) @(negedge clk_sys);
        check({carry, count}, 5'h00);
        arst_n = 1'b1;
        @(posedge clk_sys);
        #1;
        t_load;
        t_count;
        t_clear;
        end_of_test;
    end

    // About six times the expected run
    initial
    begin
        #12000;
        mismatches++;
        end_of_test;
    end
endmodule
